/* File: hw/tsr_spi_slave.sv */
// serial slave that turns host frames into register read requests
`timescale 1ns/1ns
`default_nettype none
module tsr_spi_slave (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic spi_sel_n_in,
  input wire logic spi_clk_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_n_out,
  tsr_read_if.slave_end rd_if
);
  tsr_pkg::tsr_spi_state_type q;
  tsr_pkg::tsr_spi_state_type d;
  logic sel_n;
  logic sclk;
  logic mosi;
  logic rise;
  logic fall;

  assign sel_n = q.sync[2];
  assign sclk = q.sync[1];
  assign mosi = q.sync[0];
  assign rise = sclk & ~q.clk_prev;
  assign fall = ~sclk & q.clk_prev;

  always_comb begin
    d = q;
    d.meta = {spi_sel_n_in, spi_clk_in, spi_mosi_in};
    d.sync = q.meta;
    d.clk_prev = sclk;
    d.rd_req = 1'b0;
    if (sel_n) begin
      d.bit_cnt = 5'h00;
      d.is_read = 1'b0;
      d.miso = 1'b0;
      d.miso_oe_n = 1'b1;
    end else begin
      d.miso_oe_n = 1'b0;
      if (rise && q.bit_cnt < tsr_pkg::FRAME_BITS) begin
        d.bit_cnt = q.bit_cnt + 5'h01;
        if (q.bit_cnt < tsr_pkg::CMD_BITS) begin
          d.cmd = {q.cmd[6:0], mosi};
        end
        // command byte complete: ask the bank before the first data edge
        if (q.bit_cnt == tsr_pkg::CMD_BITS - 5'h01) begin
          d.is_read = q.cmd[tsr_pkg::BIT_READ_CMD - 1];
          d.rd_req = q.cmd[tsr_pkg::BIT_READ_CMD - 1];
        end
      end
      if (fall && q.is_read && q.bit_cnt >= tsr_pkg::CMD_BITS) begin
        d.miso = q.shift_out[15];
        d.shift_out = {q.shift_out[14:0], 1'b0};
      end
    end
    if (rd_if.rd_valid) begin
      d.shift_out = rd_if.rd_data;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // idle pin levels (select high, clock low) so no false clock edge after reset
      q <= '{meta: 3'h4, sync: 3'h4, clk_prev: 1'b0, bit_cnt: 5'h00, cmd: 8'h00,
             is_read: 1'b0, shift_out: 16'h0000, miso: 1'b0, miso_oe_n: 1'b1,
             rd_req: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign rd_if.rd_req = q.rd_req;
  assign rd_if.rd_addr = q.cmd[5:0];
  assign spi_miso_out = q.miso;
  assign spi_miso_oe_n_out = q.miso_oe_n;
endmodule
`default_nettype wire

/* File: hw/tsr_status_bank.sv */
// status readback register bank of the transceiver
//
// What this block does
// - packet mode: transmit finished sets bit six
// - stream mode: next word wanted sets bit six
// - channel assessment finished sets bit five
// - third match equal timer sets bit four
// - fourth match equal timer sets bit three
// - second or short alternate match sets two
// - bit one shows channel busy result
// - energy detect type holds busy bit low
// - bit zero shows crc good, default zero
// - any reset clears the reset indicator
// - reading indicator register sets indicator until the next reset
// - high timer register gives top eight bits
// - low timer register gives bottom sixteen bits
// - sensed input pins show their level
`timescale 1ns/1ns
`default_nettype none
module tsr_status_bank (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic soft_reset_in,
  input wire logic spi_sel_n_in,
  input wire logic spi_clk_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_n_out,
  input wire logic stream_mode_in,
  input wire logic tx_packet_done_in,
  input wire logic tx_word_needed_in,
  input wire logic cca_done_in,
  input wire logic cca_busy_in,
  input wire logic [1:0] cca_type_in,
  input wire logic crc_done_in,
  input wire logic crc_ok_in,
  input wire logic count_tick_in,
  input wire logic [23:0] second_match_value_in,
  input wire logic [23:0] third_match_value_in,
  input wire logic [23:0] fourth_match_value_in,
  input wire logic [15:0] alternate_short_match_in,
  input wire logic alternate_match_enable_in,
  input wire logic [6:0] pin_input_level_in,
  input wire logic [6:0] pin_drive_enable_in,
  input wire logic [6:0] pin_sense_enable_in
);
  tsr_read_if rd_if ();
  tsr_pkg::tsr_main_state_type q;
  tsr_pkg::tsr_main_state_type d;
  logic [23:0] count_next;
  logic [15:0] set_vec;
  logic read_flags;
  logic read_ind;
  logic [15:0] read_word;
  logic [6:0] pins_sensed;

  // full width timer compare
  function automatic logic hit_full(input logic [23:0] a, input logic [23:0] b);
    hit_full = (a == b);
  endfunction

  // low sixteen bit compare for the alternate mode
  function automatic logic hit_short(input logic [23:0] a, input logic [15:0] b);
    hit_short = (a[15:0] == b);
  endfunction

  tsr_spi_slave u_spi (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .spi_sel_n_in(spi_sel_n_in),
    .spi_clk_in(spi_clk_in),
    .spi_mosi_in(spi_mosi_in),
    .spi_miso_out(spi_miso_out),
    .spi_miso_oe_n_out(spi_miso_oe_n_out),
    .rd_if(rd_if)
  );

  // matches fire on the tick that brings the timer onto the value, so a
  // flag read while the timer rests on the value is not raised again
  assign count_next = q.count + 24'h000001;

  always_comb begin
    set_vec = tsr_pkg::FLAGS_RESET;
    if (!stream_mode_in && tx_packet_done_in) begin
      set_vec[tsr_pkg::BIT_TX_EVENT] = 1'b1;
    end
    if (stream_mode_in && tx_word_needed_in) begin
      set_vec[tsr_pkg::BIT_TX_EVENT] = 1'b1;
    end
    if (cca_done_in) begin
      set_vec[tsr_pkg::BIT_CCA_DONE] = 1'b1;
    end
    if (count_tick_in) begin
      if (hit_full(count_next, third_match_value_in)) begin
        set_vec[tsr_pkg::BIT_MATCH_THREE] = 1'b1;
      end
      if (hit_full(count_next, fourth_match_value_in)) begin
        set_vec[tsr_pkg::BIT_MATCH_FOUR] = 1'b1;
      end
      if (alternate_match_enable_in) begin
        if (hit_short(count_next, alternate_short_match_in)) begin
          set_vec[tsr_pkg::BIT_MATCH_TWO] = 1'b1;
        end
      end else if (hit_full(count_next, second_match_value_in)) begin
        set_vec[tsr_pkg::BIT_MATCH_TWO] = 1'b1;
      end
    end
  end

  // a pin reads back only when it is an undriven, sensed input
  assign pins_sensed = q.pin_sync & ~pin_drive_enable_in & pin_sense_enable_in;

  always_comb begin
    read_flags = 1'b0;
    read_ind = 1'b0;
    read_word = tsr_pkg::UNMAPPED_DATA;
    if (rd_if.rd_addr == tsr_pkg::ADDR_IRQ_FLAGS) begin
      read_flags = rd_if.rd_req;
      read_word = q.flags;
    end else if (rd_if.rd_addr == tsr_pkg::ADDR_RESET_IND) begin
      read_ind = rd_if.rd_req;
      read_word[tsr_pkg::BIT_RESET_IND] = q.reset_ind;
    end else if (rd_if.rd_addr == tsr_pkg::ADDR_TIMER_HIGH) begin
      read_word[7:0] = q.count[23:16];
    end else if (rd_if.rd_addr == tsr_pkg::ADDR_TIMER_LOW) begin
      read_word = q.count[15:0];
    end else if (rd_if.rd_addr == tsr_pkg::ADDR_PIN_LEVELS) begin
      read_word[14:8] = pins_sensed;
    end
  end

  always_comb begin
    d = q;
    d.pin_meta = pin_input_level_in;
    d.pin_sync = q.pin_meta;
    d.rd_valid = rd_if.rd_req;
    if (rd_if.rd_req) begin
      d.rd_data = read_word;
    end
    if (count_tick_in) begin
      d.count = count_next;
    end
    // reading returns the flags, then clears event bits six to two (busy and crc bits stay); a new event wins
    if (read_flags) begin
      d.flags = q.flags & ~tsr_pkg::STICKY_MASK;
    end
    d.flags = d.flags | set_vec;
    if (cca_done_in) begin
      d.flags[tsr_pkg::BIT_CHANNEL_BUSY] = cca_busy_in;
    end
    if (cca_type_in == tsr_pkg::CCA_TYPE_ENERGY) begin
      d.flags[tsr_pkg::BIT_CHANNEL_BUSY] = 1'b0;
    end
    if (crc_done_in) begin
      d.flags[tsr_pkg::BIT_CRC_OK] = crc_ok_in;
    end
    // the first read after reset still shows zero
    if (read_ind) begin
      d.reset_ind = 1'b1;
    end
    if (soft_reset_in) begin
      d.reset_ind = 1'b0;
      d.flags = tsr_pkg::FLAGS_RESET;
      d.count = tsr_pkg::TIMER_RESET;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '{flags: tsr_pkg::FLAGS_RESET, reset_ind: 1'b0, count: tsr_pkg::TIMER_RESET,
             pin_meta: 7'h00, pin_sync: 7'h00, rd_data: 16'h0000,
             rd_valid: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign rd_if.rd_valid = q.rd_valid;
  assign rd_if.rd_data = q.rd_data;
endmodule
`default_nettype wire

/* File: shared/tsr_pkg.sv */
// constants shared by the status readback block and its serial slave
`default_nettype none
package tsr_pkg;
  // register addresses as seen on the serial port
  localparam logic [5:0] ADDR_IRQ_FLAGS = 6'h24;
  localparam logic [5:0] ADDR_RESET_IND = 6'h25;
  localparam logic [5:0] ADDR_TIMER_HIGH = 6'h26;
  localparam logic [5:0] ADDR_TIMER_LOW = 6'h27;
  localparam logic [5:0] ADDR_PIN_LEVELS = 6'h28;
  localparam int ADDR_WIDTH = 6;
  localparam int DATA_WIDTH = 16;
  localparam int TIMER_WIDTH = 24;
  localparam int SHORT_MATCH_WIDTH = 16;
  localparam int PIN_COUNT = 7;
  // field positions in the interrupt flag register
  localparam int BIT_TX_EVENT = 6;
  localparam int BIT_CCA_DONE = 5;
  localparam int BIT_MATCH_THREE = 4;
  localparam int BIT_MATCH_FOUR = 3;
  localparam int BIT_MATCH_TWO = 2;
  localparam int BIT_CHANNEL_BUSY = 1;
  localparam int BIT_CRC_OK = 0;
  localparam logic [15:0] STICKY_MASK = 16'h007C;
  // field positions in the other registers
  localparam int BIT_RESET_IND = 7;
  localparam int BIT_PIN_FIRST = 8;
  localparam int BIT_READ_CMD = 7;
  // assessment type that selects energy detect
  localparam logic [1:0] CCA_TYPE_ENERGY = 2'h2;
  // serial frame: command byte then one data word
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h18;
  // reset values
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [23:0] TIMER_RESET = 24'h000000;
  localparam logic [15:0] UNMAPPED_DATA = 16'h0000;
  typedef struct packed {
    logic [15:0] flags;
    logic reset_ind;
    logic [23:0] count;
    logic [6:0] pin_meta;
    logic [6:0] pin_sync;
    logic [15:0] rd_data;
    logic rd_valid;
  } tsr_main_state_type;
  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
    logic clk_prev;
    logic [4:0] bit_cnt;
    logic [7:0] cmd;
    logic is_read;
    logic [15:0] shift_out;
    logic miso;
    logic miso_oe_n;
    logic rd_req;
  } tsr_spi_state_type;
endpackage
`default_nettype wire

/* File: shared/tsr_read_if.sv */
// read request and answer between the serial slave and the register bank
`timescale 1ns/1ns
`default_nettype none
interface tsr_read_if;
  logic rd_req;
  logic [5:0] rd_addr;
  logic rd_valid;
  logic [15:0] rd_data;
  modport slave_end (output rd_req, output rd_addr, input rd_valid, input rd_data);
  modport bank_end (input rd_req, input rd_addr, output rd_valid, output rd_data);
endinterface
`default_nettype wire

/* File: sim/tsr_host_model.sv */
// host serial master issuing register command frames
`timescale 1ns/1ns
`default_nettype none
module tsr_host_model (
  input wire logic clock_in,
  input wire logic miso_in,
  output logic sel_n_out = 1'b1,
  output logic sclk_out = 1'b0,
  output logic mosi_out = 1'b0,
  output logic done_out = 1'b0,
  output logic [15:0] data_out = 16'h0000
);
  // hp sets the serial half period, so reads can be prompt or slow
  task automatic read(input logic [7:0] cmd, input int hp);
    logic [23:0] frame;
    frame = {cmd, 16'h0000};
    sel_n_out <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      mosi_out <= frame[i];
      repeat (hp) @(posedge clock_in);
      if (i < 16)
        data_out[i] <= miso_in;
      sclk_out <= 1'b1;
      repeat (hp) @(posedge clock_in);
      sclk_out <= 1'b0;
    end
    repeat (hp) @(posedge clock_in);
    sel_n_out <= 1'b1;
    mosi_out <= ~mosi_out;
    done_out <= 1'b1;
    @(posedge clock_in);
    done_out <= 1'b0;
    repeat (4) @(posedge clock_in);
  endtask
endmodule
`default_nettype wire

/* File: sim/tsr_status_bank_props.sv */
// serial pin assertions for the status bank
`timescale 1ns/1ns
`default_nettype none
module tsr_status_bank_props (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic spi_sel_n_in,
  input wire logic spi_clk_in,
  input wire logic spi_miso_out,
  input wire logic spi_miso_oe_n_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // select goes through a two-flop synchroniser, hence the slack
  sequence sel_taken_s;
    $fell(spi_sel_n_in) ##1 !spi_sel_n_in [*5];
  endsequence
  sequence sel_idle_s;
    spi_sel_n_in [*6];
  endsequence
  sel_drive_a: assert property (sel_taken_s |-> !spi_miso_oe_n_out)
    else $error("miso not driven in frame");
  sel_release_a: assert property ($rose(spi_sel_n_in) |-> ##[1:5] spi_miso_oe_n_out)
    else $error("miso not released");
  idle_miso_low_a: assert property (sel_idle_s |-> !spi_miso_out)
    else $error("miso high while idle");
  idle_no_drive_a: assert property (sel_idle_s |-> spi_miso_oe_n_out)
    else $error("miso driven while idle");
  miso_on_fall_a: assert property ($changed(spi_miso_out) |-> !spi_clk_in)
    else $error("miso moved in high phase");
  oe_on_low_a: assert property ($changed(spi_miso_oe_n_out) |-> !spi_clk_in)
    else $error("enable moved in high phase");
  drive_holds_a: assert property (!spi_miso_oe_n_out && !spi_sel_n_in |=> !spi_miso_oe_n_out)
    else $error("drive dropped in frame");
  reset_exit_a: assert property ($rose(rst_n_in) |-> spi_miso_oe_n_out && !spi_miso_out)
    else $error("pins active out of reset");
endmodule
bind tsr_status_bank tsr_status_bank_props i_tsr_status_bank_props (.clock_in(clock_in),
  .rst_n_in(rst_n_in), .spi_sel_n_in(spi_sel_n_in), .spi_clk_in(spi_clk_in),
  .spi_miso_out(spi_miso_out), .spi_miso_oe_n_out(spi_miso_oe_n_out));
`default_nettype wire

/* File: sim/tsr_status_bank_tb.sv */
// self-checking bench for the status readback bank
`timescale 1ns/1ns
`default_nettype none
module tsr_status_bank_tb;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic soft_reset_in = 1'b0;
  logic stream_mode_in = 1'b0, cca_busy_in = 1'b0, crc_ok_in = 1'b0, count_tick_in = 1'b0;
  logic alternate_match_enable_in = 1'b0;
  logic [1:0] cca_type_in = 2'h0;
  logic [3:0] ev_q = 4'h0;
  logic [23:0] second_match_value_in = 24'hFFFFFF, third_match_value_in = 24'hFFFFFF;
  logic [23:0] fourth_match_value_in = 24'hFFFFFF, cnt = 24'h000000;
  logic [15:0] alternate_short_match_in = 16'hFFFF, pin_exp;
  logic [6:0] pin_input_level_in = 7'h00, pin_drive_enable_in = 7'h00;
  logic [6:0] pin_sense_enable_in = 7'h00;
  logic [15:0] exp_q[$];
  int err_count = 0, n_checks = 0, cyc = 0, seed = 32'h6B08;
  wire logic spi_sel_n_in, spi_clk_in, spi_mosi_in, spi_miso_out, spi_miso_oe_n_out, host_done;
  wire logic [15:0] host_data;
  // released miso floats to its pull-up level
  wire logic miso_w = spi_miso_oe_n_out ? 1'b1 : spi_miso_out;
  always #25 clock_in = ~clock_in;
  tsr_status_bank i_tsr_status_bank (.clock_in, .rst_n_in, .soft_reset_in, .spi_sel_n_in,
    .spi_clk_in, .spi_mosi_in, .spi_miso_out, .spi_miso_oe_n_out, .stream_mode_in,
    .tx_packet_done_in(ev_q[0]), .tx_word_needed_in(ev_q[1]), .cca_done_in(ev_q[2]),
    .cca_busy_in, .cca_type_in, .crc_done_in(ev_q[3]), .crc_ok_in, .count_tick_in,
    .second_match_value_in, .third_match_value_in, .fourth_match_value_in,
    .alternate_short_match_in, .alternate_match_enable_in, .pin_input_level_in,
    .pin_drive_enable_in, .pin_sense_enable_in);
  tsr_host_model i_tsr_host_model (.clock_in, .miso_in(miso_w), .sel_n_out(spi_sel_n_in),
    .sclk_out(spi_clk_in), .mosi_out(spi_mosi_in), .done_out(host_done), .data_out(host_data));
  task automatic check_word(input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    i_tsr_host_model.read({2'h2, a}, 6 + ($random(seed) & 7));
  endtask
  // write frames are ignored: miso stays low for the whole frame
  task automatic wr(input logic [5:0] a);
    exp_q.push_back(16'h0000);
    i_tsr_host_model.read({2'h0, a}, 6 + ($random(seed) & 7));
  endtask
  task automatic ev(input logic [3:0] m);
    ev_q <= m;
    @(posedge clock_in);
    ev_q <= 4'h0;
    @(posedge clock_in);
  endtask
  task automatic ticks(input int n);
    count_tick_in <= 1'b1;
    repeat (n) @(posedge clock_in);
    count_tick_in <= 1'b0;
    cnt = cnt + n[23:0];
    @(posedge clock_in);
  endtask
  task final_report;
    if (err_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc++;
    if (host_done === 1'b1)
      check_word(exp_q.pop_front(), host_data);
    if (cyc == 95000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    repeat (4) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rd(6'h24, 16'h0000);
    rd(6'h25, 16'h0000);
    rd(6'h25, 16'h0080);
    rd(6'h29, 16'h0000);
    soft_reset_in <= 1'b1;
    @(posedge clock_in);
    soft_reset_in <= 1'b0;
    wr(6'h25);
    rd(6'h25, 16'h0000);
    ticks(32'h00010105);
    rd(6'h26, 16'h0001);
    rd(6'h27, 16'h0105);
    second_match_value_in <= cnt + 24'h000002;
    third_match_value_in <= cnt + 24'h000003;
    fourth_match_value_in <= cnt + 24'h000005;
    ticks(6);
    rd(6'h24, 16'h001C);
    rd(6'h24, 16'h0000);
    alternate_match_enable_in <= 1'b1;
    second_match_value_in <= 24'hFFFFFF;
    alternate_short_match_in <= cnt[15:0] + 16'h0002;
    ticks(2);
    rd(6'h24, 16'h0004);
    ev(4'h2);
    rd(6'h24, 16'h0000);
    ev(4'h1);
    rd(6'h24, 16'h0040);
    stream_mode_in <= 1'b1;
    ev(4'h1);
    rd(6'h24, 16'h0000);
    ev(4'h2);
    rd(6'h24, 16'h0040);
    cca_busy_in <= 1'b1;
    crc_ok_in <= 1'b1;
    ev(4'hC);
    rd(6'h24, 16'h0023);
    rd(6'h24, 16'h0003);
    cca_type_in <= 2'h2;
    ev(4'h4);
    rd(6'h24, 16'h0021);
    repeat (3) begin
      pin_input_level_in <= 7'($random(seed));
      pin_drive_enable_in <= 7'($random(seed));
      pin_sense_enable_in <= 7'($random(seed));
      repeat (4) @(posedge clock_in);
      pin_exp = {1'b0, pin_input_level_in & ~pin_drive_enable_in & pin_sense_enable_in, 8'h00};
      rd(6'h28, pin_exp);
    end
    final_report();
  end
endmodule
`default_nettype wire
